// ### design/tm8_pkg.sv
// Shared constants for the 8-bit timer waveform block.
package tm8_pkg;
	// Wishbone address width and register byte offsets.
	localparam int unsigned ADR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_COMPARE = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_PIN = 8'h10;
	// Control register fields.
	localparam int unsigned CTRL_WGM_LSB = 0;
	localparam int unsigned CTRL_COM_LSB = 2;
	localparam int unsigned CTRL_FORCE_BIT = 7;
	// Flag register fields.
	localparam int unsigned FLAG_OVF_BIT = 0;
	localparam int unsigned FLAG_CMP_BIT = 1;
	// Pin register fields.
	localparam int unsigned PIN_DIR_BIT = 0;
	localparam int unsigned PIN_PORT_BIT = 1;
	localparam int unsigned PIN_IN_BIT = 2;
	// Waveform modes.
	localparam logic [1:0] WGM_NORMAL = 2'h0;
	localparam logic [1:0] WGM_PHASE = 2'h1;
	localparam logic [1:0] WGM_CTC = 2'h2;
	localparam logic [1:0] WGM_FAST = 2'h3;
	// Compare output modes.
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	// Counter extremes and reset values.
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_BIT = 1'b0;
	localparam logic RST_UP = 1'b1;
endpackage : tm8_pkg

// ### design/tm8_sync2.sv
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module tm8_sync2 #(
	parameter int unsigned W = 1
) (
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic [W-1:0] async_i, // Level from outside the domain.
	output logic [W-1:0] sync_o // Level safe to use in this domain.
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// The first stage is read only by the second stage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule : tm8_sync2
`default_nettype wire

// ### design/tm8_oc_state.sv
// Compare output state flop with set, clear and toggle actions.
`timescale 1ns/100ps
`default_nettype none
module tm8_oc_state (
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic set_i, // Drive the state high.
	input wire logic clr_i, // Drive the state low.
	input wire logic tgl_i, // Invert the state.
	output logic state_o // Current compare output state.
);
	logic state_ff;

	// Reset forces the state low no matter what the pin shows.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= tm8_pkg::RST_BIT;
		end else if (set_i) begin
			state_ff <= 1'b1;
		end else if (clr_i) begin
			state_ff <= 1'b0;
		end else if (tgl_i) begin
			state_ff <= ~state_ff;
		end
	end

	assign state_o = state_ff;
endmodule : tm8_oc_state
`default_nettype wire

// ### design/tm8_timer.sv
// Timer counter with waveform modes, compare output and Wishbone register slave.
`timescale 1ns/100ps
`default_nettype none

module tm8_timer (
	input wire logic clk_i, // System clock, 40 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic tick_i, // Prescaled timer clock enable, one cycle.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic [tm8_pkg::ADR_W-1:0] wb_adr_i, // Wishbone byte address.
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
	input wire logic [31:0] wb_dat_i, // Wishbone write data.
	output logic [31:0] wb_dat_o, // Wishbone read data.
	output logic wb_ack_o, // Wishbone acknowledge.
	input wire logic pin_i, // Level seen on the output pin.
	output logic pin_o, // Value driven onto the pin.
	output logic pin_oe_n_o, // Pin driver enable, low drives.
	output logic overflow_flag_o, // Sticky overflow flag.
	output logic compare_match_flag_o // Sticky compare match flag.
);
	// Control and datapath registers.
	logic [1:0] waveform_mode_ff;
	logic [1:0] compare_output_mode_ff;
	logic [7:0] counter_value_ff;
	logic [7:0] compare_buf_ff;
	logic [7:0] compare_value_ff;
	logic count_up_ff;
	logic block_ff;
	logic force_ff;
	logic overflow_flag_ff;
	logic compare_match_flag_ff;
	logic output_pin_direction_ff;
	logic port_value_ff;
	logic pin_out_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;

	// Decoded bus access.
	logic bus_acc;
	logic wr_en;
	logic wr_ctrl;
	logic wr_count;
	logic wr_compare;
	logic wr_flags;
	logic wr_pin;
	logic [7:0] wbyte;
	logic pin_sync;

	// Timer events.
	logic is_pwm;
	logic at_max;
	logic at_bottom;
	logic cmp_equal;
	logic match;
	logic [7:0] nxt_counter;
	logic nxt_up;
	logic ovf_evt;
	logic reload_evt;
	logic act_set;
	logic act_clr;
	logic act_tgl;
	logic oc_state;
	logic down_act;

	// A request is taken once; ack drops in the cycle after it was given.
	assign bus_acc = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_en = bus_acc & wb_we_i & wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];
	assign wr_ctrl = wr_en & (wb_adr_i == tm8_pkg::OFS_CTRL);
	assign wr_count = wr_en & (wb_adr_i == tm8_pkg::OFS_COUNT);
	assign wr_compare = wr_en & (wb_adr_i == tm8_pkg::OFS_COMPARE);
	assign wr_flags = wr_en & (wb_adr_i == tm8_pkg::OFS_FLAGS);
	assign wr_pin = wr_en & (wb_adr_i == tm8_pkg::OFS_PIN);

	// The pin readback comes from outside the clock domain.
	tm8_sync2 #(
		.W(1)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(pin_i),
		.sync_o(pin_sync)
	);

	// Acknowledge and read data; unmapped addresses answer with zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rdata_ff <= '0;
		end else begin
			ack_ff <= bus_acc;
			if (bus_acc) begin
				rdata_ff <= '0;
				case (wb_adr_i)
					tm8_pkg::OFS_CTRL: begin
						rdata_ff[tm8_pkg::CTRL_WGM_LSB +: 2] <= waveform_mode_ff;
						rdata_ff[tm8_pkg::CTRL_COM_LSB +: 2] <= compare_output_mode_ff;
					end
					tm8_pkg::OFS_COUNT: begin
						rdata_ff[7:0] <= counter_value_ff;
					end
					tm8_pkg::OFS_COMPARE: begin
						rdata_ff[7:0] <= compare_buf_ff;
					end
					tm8_pkg::OFS_FLAGS: begin
						rdata_ff[tm8_pkg::FLAG_OVF_BIT] <= overflow_flag_ff;
						rdata_ff[tm8_pkg::FLAG_CMP_BIT] <= compare_match_flag_ff;
					end
					tm8_pkg::OFS_PIN: begin
						rdata_ff[tm8_pkg::PIN_DIR_BIT] <= output_pin_direction_ff;
						rdata_ff[tm8_pkg::PIN_PORT_BIT] <= port_value_ff;
						rdata_ff[tm8_pkg::PIN_IN_BIT] <= pin_sync;
					end
					default: begin
						rdata_ff <= '0;
					end
				endcase
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;

	// Mode and output mode; a new output mode switches the pin source at once and acts from the next match.
	// next match acts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			waveform_mode_ff <= tm8_pkg::WGM_NORMAL;
			compare_output_mode_ff <= tm8_pkg::COM_OFF;
		end else if (wr_ctrl) begin
			waveform_mode_ff <= wbyte[tm8_pkg::CTRL_WGM_LSB +: 2];
			compare_output_mode_ff <= wbyte[tm8_pkg::CTRL_COM_LSB +: 2];
		end
	end

	// The force bit is a strobe: it never stores and reads as zero.
	// force in non-PWM
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			force_ff <= 1'b0;
		end else begin
			force_ff <= wr_ctrl & wbyte[tm8_pkg::CTRL_FORCE_BIT] &
				~wbyte[tm8_pkg::CTRL_WGM_LSB];
		end
	end

	// Pin direction and general port value.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			output_pin_direction_ff <= tm8_pkg::RST_BIT;
			port_value_ff <= tm8_pkg::RST_BIT;
		end else if (wr_pin) begin
			output_pin_direction_ff <= wbyte[tm8_pkg::PIN_DIR_BIT];
			port_value_ff <= wbyte[tm8_pkg::PIN_PORT_BIT];
		end
	end

	assign is_pwm = waveform_mode_ff[0];
	assign at_max = (counter_value_ff == tm8_pkg::CNT_MAX);
	assign at_bottom = (counter_value_ff == tm8_pkg::CNT_BOTTOM);
	assign cmp_equal = (counter_value_ff == compare_value_ff);

	assign match = cmp_equal & ~block_ff;

	// The block lasts until one timer tick has passed, so it also holds while stopped.
	// block for one tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			block_ff <= 1'b0;
		end else if (wr_count) begin
			block_ff <= 1'b1;
		end else if (tick_i) begin
			block_ff <= 1'b0;
		end
	end

	// Next counter value and direction for each waveform mode.
	always_comb begin
		nxt_counter = counter_value_ff + 8'h01;
		nxt_up = count_up_ff;
		ovf_evt = 1'b0;
		reload_evt = 1'b0;
		case (waveform_mode_ff)
			tm8_pkg::WGM_NORMAL: begin
				ovf_evt = at_max;
			end
			tm8_pkg::WGM_CTC: begin
				if (match) begin
					nxt_counter = tm8_pkg::CNT_BOTTOM;
				end
				ovf_evt = at_max; // A clear at 0xff still passes the count from MAX to zero.
			end
			tm8_pkg::WGM_FAST: begin
				if (at_max) begin
					nxt_counter = tm8_pkg::CNT_BOTTOM;
				end
				ovf_evt = at_max;
				reload_evt = at_max;
			end
			tm8_pkg::WGM_PHASE: begin
				if (count_up_ff) begin
					if (at_max) begin
						nxt_counter = tm8_pkg::CNT_MAX - 8'h01;
						nxt_up = 1'b0;
					end
				end else if (at_bottom) begin
					nxt_up = 1'b1;
				end else begin
					nxt_counter = counter_value_ff - 8'h01;
				end
				ovf_evt = ~count_up_ff & (counter_value_ff == 8'h01);
				reload_evt = count_up_ff & at_max;
			end
			default: begin
				nxt_counter = counter_value_ff;
			end
		endcase
	end

	// A software write has priority over any count or clear on the same edge.
	// tick qualified
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			counter_value_ff <= tm8_pkg::RST_BYTE;
			count_up_ff <= tm8_pkg::RST_UP;
		end else if (wr_count) begin
			counter_value_ff <= wbyte;
		end else if (tick_i) begin
			counter_value_ff <= nxt_counter;
			count_up_ff <= (waveform_mode_ff == tm8_pkg::WGM_PHASE) ? nxt_up : 1'b1;
		end
	end

	// Software writes the buffer; the active value follows it directly or at reload.
	// double buffer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			compare_buf_ff <= tm8_pkg::RST_BYTE;
			compare_value_ff <= tm8_pkg::RST_BYTE;
		end else begin
			if (wr_compare) begin
				compare_buf_ff <= wbyte;
			end
			if (~is_pwm) begin
				compare_value_ff <= wr_compare ? wbyte : compare_buf_ff;
			end else if (tick_i & reload_evt) begin
				compare_value_ff <= compare_buf_ff;
			end
		end
	end

	// Sticky flags: hardware only sets, software writes one to clear, set wins.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_flag_ff <= tm8_pkg::RST_BIT;
			compare_match_flag_ff <= tm8_pkg::RST_BIT;
		end else begin
			if (tick_i & ovf_evt) begin
				overflow_flag_ff <= 1'b1;
			end else if (wr_flags & wbyte[tm8_pkg::FLAG_OVF_BIT]) begin
				overflow_flag_ff <= 1'b0;
			end
			if (tick_i & match) begin
				compare_match_flag_ff <= 1'b1;
			end else if (wr_flags & wbyte[tm8_pkg::FLAG_CMP_BIT]) begin
				compare_match_flag_ff <= 1'b0;
			end
		end
	end

	assign overflow_flag_o = overflow_flag_ff;
	assign compare_match_flag_o = compare_match_flag_ff;

	// Phase-correct: a match at the top acts as a down match, at zero as an up match.
	assign down_act = at_max ? 1'b1 : (at_bottom ? 1'b0 : ~count_up_ff);

	// Compare output actions; output mode zero never acts.
	// mode zero no action
	always_comb begin
		act_set = 1'b0;
		act_clr = 1'b0;
		act_tgl = 1'b0;
		case (waveform_mode_ff)
			tm8_pkg::WGM_NORMAL, tm8_pkg::WGM_CTC: begin
				if ((tick_i & match) | force_ff) begin
					act_tgl = (compare_output_mode_ff == tm8_pkg::COM_TOGGLE);
					act_clr = (compare_output_mode_ff == tm8_pkg::COM_CLEAR);
					act_set = (compare_output_mode_ff == tm8_pkg::COM_SET);
				end
			end
			tm8_pkg::WGM_FAST: begin
				act_tgl = tick_i & match & (compare_output_mode_ff == tm8_pkg::COM_TOGGLE);
				if (tick_i & compare_output_mode_ff[1]) begin
					if (at_max) begin
						act_set = ~compare_output_mode_ff[0];
						act_clr = compare_output_mode_ff[0];
					end else if (match) begin
						act_set = compare_output_mode_ff[0];
						act_clr = ~compare_output_mode_ff[0];
					end
				end
			end
			tm8_pkg::WGM_PHASE: begin
				if (tick_i & match & compare_output_mode_ff[1]) begin
					act_set = down_act ^ compare_output_mode_ff[0];
					act_clr = ~(down_act ^ compare_output_mode_ff[0]);
				end
			end
			default: begin
				act_set = 1'b0;
			end
		endcase
	end

	tm8_oc_state u_oc_state (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(act_set),
		.clr_i(act_clr),
		.tgl_i(act_tgl),
		.state_o(oc_state)
	);

	// Pin value is registered so the pad never sees decode glitches.
	// override port value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_out_ff <= tm8_pkg::RST_BIT;
		end else if (compare_output_mode_ff != tm8_pkg::COM_OFF) begin
			pin_out_ff <= oc_state;
		end else begin
			pin_out_ff <= port_value_ff;
		end
	end

	// Direction stays with software; the driver is off until it selects output.
	// direction gates pin
	assign pin_o = pin_out_ff;
	assign pin_oe_n_o = ~output_pin_direction_ff;
endmodule : tm8_timer
`default_nettype wire

// ### verification/tm8_timer_properties.sv
// Port-level assertions for the timer waveform block.
`timescale 1ns/100ps
`default_nettype none
module tm8_timer_properties (
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset.
	input wire logic tick_i, // Timer tick.
	input wire logic wb_cyc_i, // Bus cycle.
	input wire logic wb_stb_i, // Bus strobe.
	input wire logic wb_we_i, // Bus write.
	input wire logic [tm8_pkg::ADR_W-1:0] wb_adr_i, // Bus address.
	input wire logic wb_ack_o, // Bus acknowledge.
	input wire logic pin_o, // Pin value.
	input wire logic pin_oe_n_o, // Pin enable, low drives.
	input wire logic overflow_flag_o, // Overflow flag.
	input wire logic compare_match_flag_o // Match flag.
);
	logic [2:0] tk_h;
	logic [2:0] wr_h;
	logic wr_now;
	// A pin change needs a tick or a write within three cycles, since the pin lags the state.
	assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i;
	always_ff @(posedge clk_i) begin
		tk_h <= {tk_h[1:0], tick_i};
	end
	// History of bus writes.
	always_ff @(posedge clk_i) begin
		wr_h <= {wr_h[1:0], wr_now};
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Acknowledge is a single pulse.
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held too long.");
	// A taken request is answered next cycle.
	chk_ack_timing: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Acknowledge late.");
	chk_reset_state: assert property (
		$fell(rst_i) |-> !pin_o && pin_oe_n_o && !overflow_flag_o && !compare_match_flag_o)
		else $error("Pin or flags not cleared by reset.");
	chk_ovf_tick: assert property ($rose(overflow_flag_o) |-> $past(tick_i))
		else $error("Overflow set without a tick.");
	chk_cmp_tick: assert property ($rose(compare_match_flag_o) |-> $past(tick_i))
		else $error("Match flag set without a tick.");
	chk_ovf_sticky: assert property (
		$fell(overflow_flag_o) |-> $past(wr_now && wb_adr_i == tm8_pkg::OFS_FLAGS))
		else $error("Overflow cleared without a flag write.");
	chk_oe_dir: assert property (
		$changed(pin_oe_n_o) |-> $past(wr_now && wb_adr_i == tm8_pkg::OFS_PIN))
		else $error("Pin enable moved without a pin write.");
	chk_pin_cause: assert property (
		$changed(pin_o) |-> (tk_h != 3'h0 || wr_h != 3'h0))
		else $error("Pin changed without tick or write.");
	cov_overflow: cover property ($rose(overflow_flag_o));
	cov_match: cover property ($rose(compare_match_flag_o));
	cov_pin: cover property ($rose(pin_o));
endmodule : tm8_timer_properties
bind tm8_timer tm8_timer_properties u_tm8_timer_properties (.clk_i, .rst_i, .tick_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .pin_o, .pin_oe_n_o,
	.overflow_flag_o, .compare_match_flag_o);
`default_nettype wire

// ### verification/tm8_pin_load.sv
// Board side of the compare output pin.
`timescale 1ns/100ps
`default_nettype none
module tm8_pin_load (
	input wire logic drv_i, // Value driven by the timer.
	input wire logic oe_n_i, // Driver enable, low drives.
	output logic pad_o // Level on the pad.
);
	// released pin floats high through the pull-up, so stale data never shows.
	assign pad_o = oe_n_i ? 1'b1 : drv_i;
endmodule : tm8_pin_load
`default_nettype wire

// ### verification/tm8_timer_test.sv
// Self-checking bench for the timer waveform block.
`timescale 1ns/100ps
`default_nettype none
module tm8_timer_test;
	localparam logic [7:0] AC = tm8_pkg::OFS_CTRL;
	localparam logic [7:0] AN = tm8_pkg::OFS_COUNT;
	localparam logic [7:0] AP = tm8_pkg::OFS_COMPARE;
	localparam logic [7:0] AF = tm8_pkg::OFS_FLAGS;
	localparam logic [7:0] AI = tm8_pkg::OFS_PIN;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic tick_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [tm8_pkg::ADR_W-1:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic pin_i;
	logic pin_o;
	logic pin_oe_n_o;
	logic overflow_flag_o;
	logic compare_match_flag_o;
	int fails = 0;
	int comparisons = 0;
	// System clock at 40 MHz.
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	tm8_timer u_tm8_timer (.clk_i, .rst_i, .tick_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_i, .pin_o,
		.pin_oe_n_o, .overflow_flag_o, .compare_match_flag_o);
	tm8_pin_load u_tm8_pin_load (.drv_i(pin_o), .oe_n_i(pin_oe_n_o), .pad_o(pin_i));
	task automatic conclude;
		if (fails == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
			fails++;
		end
	endtask : chk
	// One classic cycle; the request holds until ack is sampled high at an edge.
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] r);
		int n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			fails++;
			conclude();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] r;
		bus(a, 1'b0, 8'h00, r);
		chk(r, {24'h0, e});
	endtask : rd
	// Timer ticks with an idle cycle between them.
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk_i);
			tick_i <= 1'b1;
			@(posedge clk_i);
			tick_i <= 1'b0;
		end
	endtask : tk
	// The pin lags the state by a clock, so let two edges pass.
	task automatic pn(input logic e);
		repeat (2) @(posedge clk_i);
		chk({31'h0, pin_o}, {31'h0, e});
	endtask : pn
	// Main sequence.
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({30'h0, pin_oe_n_o, pin_o}, 32'h2);
		rd(AF, 8'h00);
		rd(8'h20, 8'h00);
		// Normal mode wraps and keeps the overflow flag.
		wr(AN, 8'hfe);
		tk(1);
		rd(AN, 8'hff);
		rd(AF, 8'h00);
		tk(1);
		rd(AN, 8'h00);
		tk(1);
		rd(AF, 8'h03);
		chk({30'h0, compare_match_flag_o, overflow_flag_o}, 32'h3);
		// Port value versus the compare state on the pin.
		wr(AI, 8'h03);
		pn(1'b1);
		chk({31'h0, pin_oe_n_o}, 32'h0);
		rd(AI, 8'h07);
		wr(AC, 8'h08);
		pn(1'b0);
		wr(AC, 8'h8c);
		pn(1'b1);
		wr(AC, 8'h8b);
		pn(1'b1);
		wr(AI, 8'h01);
		pn(1'b1);
		wr(AC, 8'h03);
		pn(1'b0);
		// Clear-on-match with toggling output.
		wr(AC, 8'h06);
		wr(AP, 8'h03);
		wr(AN, 8'h00);
		wr(AF, 8'h03);
		tk(3);
		rd(AN, 8'h03);
		tk(1);
		rd(AN, 8'h00);
		rd(AF, 8'h02);
		chk({31'h0, compare_match_flag_o}, 32'h1);
		pn(1'b0);
		tk(4);
		pn(1'b1);
		// A counter write hides the next match.
		wr(AN, 8'h03);
		tk(1);
		rd(AN, 8'h04);
		pn(1'b1);
		// Compare below the count is missed until the wrap.
		wr(AF, 8'h03);
		tk(252);
		rd(AN, 8'h00);
		rd(AF, 8'h01);
		wr(AC, 8'h02);
		tk(4);
		wr(AC, 8'h06);
		pn(1'b1);
		wr(AC, 8'h8a);
		pn(1'b0);
		// Fast PWM with compare zero gives a one-tick spike.
		wr(AC, 8'h0b);
		wr(AP, 8'h00);
		wr(AN, 8'hfe);
		wr(AF, 8'h03);
		tk(1);
		rd(AN, 8'hff);
		tk(1);
		rd(AN, 8'h00);
		rd(AF, 8'h01);
		pn(1'b1);
		tk(1);
		pn(1'b0);
		// Phase correct turns at the maximum and sets on the way down.
		wr(AC, 8'h09);
		wr(AP, 8'h80);
		wr(AN, 8'hfe);
		tk(1);
		rd(AN, 8'hff);
		tk(1);
		rd(AN, 8'hfe);
		tk(127);
		pn(1'b1);
		rd(AN, 8'h7f);
		wr(AF, 8'h03);
		tk(126);
		rd(AF, 8'h00);
		tk(1);
		rd(AF, 8'h01);
		tk(129);
		pn(1'b0);
		// Fast PWM toggling keeps the compare value double buffered.
		wr(AC, 8'h07);
		wr(AN, 8'h7e);
		tk(3);
		pn(1'b1);
		wr(AP, 8'h90);
		rd(AP, 8'h90);
		tk(16);
		pn(1'b1);
		// Inverting output with the compare at maximum stays low for a whole period.
		wr(AC, 8'h0f);
		wr(AP, 8'hff);
		tk(111);
		pn(1'b0);
		tk(256);
		rd(AN, 8'h00);
		pn(1'b0);
		conclude();
	end
endmodule : tm8_timer_test
`default_nettype wire
